/* rtl/fws_pkg.sv */
// Constants and types shared by the flash status poller files
package fws_pkg;
  // Timing: clock period, array access and gap between reads
  localparam int CLK_NS = 50;
  localparam int T_ACC_NS = 120;
  localparam int T_GAP_NS = 50;
  localparam int SYNC_STAGES = 2;
  // Output enable stays low for access time plus synchroniser latency
  localparam logic [3:0] RD_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [3:0] GAP_CYC = 4'(T_GAP_NS / CLK_NS);

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hC;

  // Control bits
  localparam int CTRL_START = 0;
  localparam int CTRL_TOGGLE = 1;
  localparam int CTRL_EXP = 2;
  localparam int CTRL_ABORT = 3;

  // Status bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_SUSP = 3;
  localparam int STAT_TOG2 = 4;
  localparam int STAT_READY = 5;
  localparam int STAT_TIMER = 6;
  localparam int STAT_TMO = 7;

  // Status bit positions on the flash data bus
  localparam int DQ_POLL = 7;
  localparam int DQ_TOG1 = 6;
  localparam int DQ_TMO = 5;
  localparam int DQ_TIMER = 3;
  localparam int DQ_TOG2 = 2;

  // Reset values
  localparam logic [20:0] ADDR_RST = 21'h000000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_GAP} fws_phase_type;
  typedef enum logic [1:0] {STP_FIRST, STP_CHECK, STP_RECHECK, STP_FINAL} fws_step_type;
endpackage

/* rtl/fws_sync.sv */
// Two-stage synchroniser for the asynchronous flash pins
`timescale 1ns/1ps
module fws_sync #(
  parameter int W = 17
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fws_sync_type;

  fws_sync_type r;
  fws_sync_type next_r;

  // First stage feeds only the second stage
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule

/* rtl/fws_poll_ctrl.sv */
// Host-side flash write status poller with Avalon-MM register port
//
// What this block does
// - Host presents program or erase sector address
// - Host takes valid data from later reads
// - Timeout flag set: reread poll or toggle bit first
// - Host combines both toggle bits for state
// - Toggle polling starts with two back-to-back reads
// - Still toggling after timeout recheck means failure
// - Resumed toggle polling restarts from double read
// - Status reads address the busy bank
`timescale 1ns/1ps
module fws_poll_ctrl (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [3:0] AV_ADDRESS,
  input wire logic AV_READ,
  input wire logic AV_WRITE,
  input wire logic [31:0] AV_WRITEDATA,
  input wire logic [3:0] AV_BYTEENABLE,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST,
  output logic [20:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  input wire logic [15:0] FL_DQ,
  input wire logic FL_READY_BUSY_N
);
  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [20:0] addr;
    logic toggle_mode;
    logic exp_poll;
    fws_pkg::fws_phase_type phase;
    fws_pkg::fws_step_type step;
    logic [3:0] cnt;
    logic busy;
    logic done;
    logic fail;
    logic susp;
    logic tog2;
    logic t1;
    logic t2;
    logic [15:0] data;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fws_state_type;

  fws_state_type q;
  fws_state_type n;
  logic [16:0] pins_s;
  logic [15:0] dq_s;
  logic rdy_s;
  logic take;
  logic wr;
  logic start;
  logic abort;
  logic sampled;
  logic [31:0] merged;
  logic [31:0] stat;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  fws_sync #(
    .W(17)
  ) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d({FL_READY_BUSY_N, FL_DQ}),
    .q(pins_s)
  );
  assign dq_s = pins_s[15:0];
  assign rdy_s = pins_s[16];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: a request is taken on its second cycle
  assign take = (AV_READ || AV_WRITE) && !q.wait_req;
  assign wr = AV_WRITE && take && AV_BYTEENABLE[0];
  assign start = wr && AV_ADDRESS == fws_pkg::REG_CTRL && AV_WRITEDATA[fws_pkg::CTRL_START]
    && !q.busy;
  assign abort = wr && AV_ADDRESS == fws_pkg::REG_CTRL && AV_WRITEDATA[fws_pkg::CTRL_ABORT]
    && q.busy;
  assign sampled = q.phase == fws_pkg::PH_READ && q.cnt == 4'h0;

  // Status word; ready pin and flags from the last sample
  always_comb begin
    stat = 32'h00000000;
    stat[fws_pkg::STAT_BUSY] = q.busy;
    stat[fws_pkg::STAT_DONE] = q.done;
    stat[fws_pkg::STAT_FAIL] = q.fail;
    stat[fws_pkg::STAT_SUSP] = q.susp;
    stat[fws_pkg::STAT_TOG2] = q.tog2;
    stat[fws_pkg::STAT_READY] = rdy_s;
    stat[fws_pkg::STAT_TIMER] = q.data[fws_pkg::DQ_TIMER];
    stat[fws_pkg::STAT_TMO] = q.data[fws_pkg::DQ_TMO];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = q;
    merged = {11'h000, q.addr};
    // One wait cycle per request, then a one-cycle answer
    n.wait_req = !((AV_READ || AV_WRITE) && q.wait_req);
    if ((AV_READ || AV_WRITE) && q.wait_req) begin
      case (AV_ADDRESS)
        fws_pkg::REG_CTRL: n.rdata = {28'h0000000, 1'b0, q.exp_poll, q.toggle_mode, 1'b0};
        fws_pkg::REG_ADDR: n.rdata = {11'h000, q.addr};
        fws_pkg::REG_STAT: n.rdata = stat;
        fws_pkg::REG_DATA: n.rdata = {16'h0000, q.data};
        default: n.rdata = 32'h00000000;
      endcase
    end
    // Address is locked while polling so reads stay on the busy bank
    if (AV_WRITE && take && AV_ADDRESS == fws_pkg::REG_ADDR && !q.busy) begin
      for (int i = 0; i < 4; i++) begin
        if (AV_BYTEENABLE[i]) begin
          merged[8*i +: 8] = AV_WRITEDATA[8*i +: 8];
        end
      end
      n.addr = merged[20:0];
    end
    if (start) begin
      // Every start begins with a fresh read, at the first read in toggle mode
      n.toggle_mode = AV_WRITEDATA[fws_pkg::CTRL_TOGGLE];
      n.exp_poll = AV_WRITEDATA[fws_pkg::CTRL_EXP];
      n.step = AV_WRITEDATA[fws_pkg::CTRL_TOGGLE] ? fws_pkg::STP_FIRST
        : fws_pkg::STP_CHECK;
      n.busy = 1'b1;
      n.done = 1'b0;
      n.fail = 1'b0;
      n.susp = 1'b0;
      n.tog2 = 1'b0;
      n.phase = fws_pkg::PH_READ;
      n.cnt = fws_pkg::RD_CYC - 4'h1;
      n.ce_n = 1'b0;
      n.oe_n = 1'b0;
    end else if (abort) begin
      n.busy = 1'b0;
      n.phase = fws_pkg::PH_IDLE;
      n.ce_n = 1'b1;
      n.oe_n = 1'b1;
    end else begin
      case (q.phase)
        fws_pkg::PH_IDLE: begin
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
        end
        fws_pkg::PH_READ: begin
          if (q.cnt != 4'h0) begin
            n.cnt = q.cnt - 4'h1;
          end else begin
            // Each read is its own OE pulse so the toggle bits advance
            n.data = dq_s;
            n.oe_n = 1'b1;
            n.phase = fws_pkg::PH_GAP;
            n.cnt = fws_pkg::GAP_CYC - 4'h1;
            n.t1 = dq_s[fws_pkg::DQ_TOG1];
            n.t2 = dq_s[fws_pkg::DQ_TOG2];
            case (q.step)
              fws_pkg::STP_FIRST: begin
                n.step = fws_pkg::STP_CHECK;
              end
              fws_pkg::STP_CHECK: begin
                if (q.toggle_mode) begin
                  n.tog2 = q.tog2 || dq_s[fws_pkg::DQ_TOG2] != q.t2;
                  if (dq_s[fws_pkg::DQ_TOG1] == q.t1) begin
                    n.step = fws_pkg::STP_FINAL;
                    n.susp = dq_s[fws_pkg::DQ_TOG2] != q.t2;
                  end else if (dq_s[fws_pkg::DQ_TMO]) begin
                    n.step = fws_pkg::STP_RECHECK;
                  end
                end else if (dq_s[fws_pkg::DQ_POLL] == q.exp_poll) begin
                  n.step = fws_pkg::STP_FINAL;
                end else if (dq_s[fws_pkg::DQ_TMO]) begin
                  n.step = fws_pkg::STP_RECHECK;
                end
              end
              fws_pkg::STP_RECHECK: begin
                if (q.toggle_mode ? dq_s[fws_pkg::DQ_TOG1] == q.t1
                    : dq_s[fws_pkg::DQ_POLL] == q.exp_poll) begin
                  n.step = fws_pkg::STP_FINAL;
                end else begin
                  // Software must now send the flash its reset command
                  n.fail = 1'b1;
                  n.done = 1'b1;
                  n.busy = 1'b0;
                  n.phase = fws_pkg::PH_IDLE;
                  n.ce_n = 1'b1;
                end
              end
              fws_pkg::STP_FINAL: begin
                // This later read carries the valid array word
                n.done = 1'b1;
                n.busy = 1'b0;
                n.phase = fws_pkg::PH_IDLE;
                n.ce_n = 1'b1;
              end
              default: n.step = fws_pkg::STP_FIRST;
            endcase
          end
        end
        fws_pkg::PH_GAP: begin
          if (q.cnt != 4'h0) begin
            n.cnt = q.cnt - 4'h1;
          end else begin
            n.phase = fws_pkg::PH_READ;
            n.cnt = fws_pkg::RD_CYC - 4'h1;
            n.oe_n = 1'b0;
          end
        end
        default: n.phase = fws_pkg::PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= '{wait_req: 1'b1, rdata: 32'h00000000, addr: fws_pkg::ADDR_RST,
        toggle_mode: 1'b0, exp_poll: 1'b0, phase: fws_pkg::PH_IDLE,
        step: fws_pkg::STP_FIRST, cnt: 4'h0, busy: 1'b0, done: 1'b0, fail: 1'b0,
        susp: 1'b0, tog2: 1'b0, t1: 1'b0, t2: 1'b0, data: fws_pkg::DATA_RST,
        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      q <= n;
    end
  end

  assign AV_READDATA = q.rdata;
  assign AV_WAITREQUEST = q.wait_req;
  assign FL_ADDR = q.addr;
  assign FL_CE_N = q.ce_n;
  assign FL_OE_N = q.oe_n;
  assign FL_WE_N = q.we_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_addr_held: assert property (q.busy && $past(q.busy) |-> $stable(FL_ADDR))
    else $error("flash address moved while polling");
  a_oe_in_ce: assert property ($fell(FL_OE_N) |-> !FL_CE_N)
    else $error("output enable without chip enable");
  a_read_width: assert property ($fell(FL_OE_N) |-> !FL_OE_N [*5] ##1 FL_OE_N)
    else $error("read pulse length wrong");
  a_two_reads: assert property (start && AV_WRITEDATA[fws_pkg::CTRL_TOGGLE]
    |=> !q.done [*8])
    else $error("toggle poll ended before two reads");
  a_fail_recheck: assert property ($rose(q.fail) |-> $past(q.step) == fws_pkg::STP_RECHECK)
    else $error("failure without recheck read");
  a_fail_idle: assert property ($rose(q.fail) |-> FL_OE_N && FL_CE_N && !q.busy)
    else $error("pins active after failure");
  a_done_final: assert property ($rose(q.done) && !q.fail
    |-> $past(q.step) == fws_pkg::STP_FINAL)
    else $error("done without following data read");
  a_restart: assert property (start && AV_WRITEDATA[fws_pkg::CTRL_TOGGLE]
    |=> q.step == fws_pkg::STP_FIRST && !FL_OE_N)
    else $error("poll did not restart at first read");
  a_abort_stop: assert property (abort |=> !q.busy ##1 FL_OE_N && FL_CE_N)
    else $error("abort did not release flash");
  a_susp_mode: assert property ($rose(q.susp) |-> q.toggle_mode)
    else $error("suspend seen outside toggle mode");
  a_bus_answer: assert property ((AV_READ || AV_WRITE) && AV_WAITREQUEST |=> !AV_WAITREQUEST)
    else $error("bus answer late");

  c_ok_done: cover property ($rose(q.done) && !q.fail);
  c_fail: cover property ($rose(q.fail));
  c_susp: cover property ($rose(q.susp));
  c_recheck: cover property (q.step == fws_pkg::STP_RECHECK && sampled);
endmodule

/* test/fws_flash_model.sv */
// Behavioural flash device answering status reads from the poller
`timescale 1ns/1ps
module fws_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic [1:0] mode,
  input wire logic [7:0] reads,
  input wire logic [15:0] word,
  input wire logic load,
  output logic [15:0] dq,
  output logic ready_busy_n
);
  // Modes: 0 program, 1 erase, 2 erase suspended, 3 stuck past pulse limit
  logic [7:0] left;
  logic tog1;
  logic tog2;
  logic busy;
  logic [15:0] st;
  ////////////////////////////////////////////////////////////////////////////
  // Each finished read while busy advances tog1 (not in suspend) and tog2 (erase modes); stuck mode never completes
  always @(posedge oe_n or posedge load) begin
    if (load) begin
      left <= reads;
      tog1 <= 1'b0;
      tog2 <= 1'b0;
    end else if (left != 8'h00) begin
      if (mode != 2'h3) begin
        left <= left - 8'h01;
      end
      if (mode != 2'h2) begin
        tog1 <= ~tog1;
      end
      if (mode == 2'h1 || mode == 2'h2) begin
        tog2 <= ~tog2;
      end
    end
  end
  assign busy = (left != 8'h00);
  // Status word while busy, array word once the algorithm is over
  always_comb begin
    st = word;
    if (busy) begin
      st[7] = (mode == 2'h1) ? 1'b0 : (mode == 2'h2) ? 1'b1 : ~word[7];
      st[6] = tog1;
      st[5] = (mode == 2'h3);
      st[3] = (mode == 2'h1);
      st[2] = (mode == 2'h1 || mode == 2'h2) ? tog2 : word[2];
    end
  end
  // Released bus shows the inverse so stale data never looks valid
  assign dq = (!ce_n && !oe_n) ? st : ~st;
  // Open-drain pin: low only while an algorithm runs, not in suspend
  assign ready_busy_n = !(busy && mode != 2'h2);
endmodule

/* test/testbench.sv */
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
module testbench;
  logic CLK;
  logic RST_B;
  logic [3:0] AV_ADDRESS;
  logic AV_READ;
  logic AV_WRITE;
  logic [31:0] AV_WRITEDATA;
  logic [3:0] AV_BYTEENABLE;
  logic [31:0] AV_READDATA;
  logic AV_WAITREQUEST;
  logic [20:0] FL_ADDR;
  logic FL_CE_N;
  logic FL_OE_N;
  logic FL_WE_N;
  logic [15:0] FL_DQ;
  logic FL_READY_BUSY_N;
  logic [1:0] fm_mode;
  logic [7:0] fm_reads;
  logic [15:0] fm_word;
  logic fm_load;
  logic [31:0] rd;
  int err_count;
  int n_checks;
  int n_reads;
  fws_poll_ctrl u_fws_poll_ctrl (.CLK(CLK), .RST_B(RST_B), .AV_ADDRESS(AV_ADDRESS),
    .AV_READ(AV_READ), .AV_WRITE(AV_WRITE), .AV_WRITEDATA(AV_WRITEDATA),
    .AV_BYTEENABLE(AV_BYTEENABLE), .AV_READDATA(AV_READDATA),
    .AV_WAITREQUEST(AV_WAITREQUEST), .FL_ADDR(FL_ADDR), .FL_CE_N(FL_CE_N),
    .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_DQ(FL_DQ), .FL_READY_BUSY_N(FL_READY_BUSY_N));
  fws_flash_model u_fws_flash_model (.ce_n(FL_CE_N), .oe_n(FL_OE_N), .mode(fm_mode),
    .reads(fm_reads), .word(fm_word), .load(fm_load), .dq(FL_DQ),
    .ready_busy_n(FL_READY_BUSY_N));
  initial CLK = 1'b0;
  always #25 CLK = ~CLK;
  // Count flash reads by output-enable falls
  always @(negedge FL_OE_N) n_reads++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle; request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge CLK);
    AV_ADDRESS <= a;
    AV_WRITEDATA <= wd;
    AV_WRITE <= wr;
    AV_READ <= !wr;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (AV_WAITREQUEST !== 1'b0 && n < 20);
    rd = AV_READDATA;
    AV_READ <= 1'b0;
    AV_WRITE <= 1'b0;
    if (AV_WAITREQUEST !== 1'b0) begin
      check(32'h1, 32'h0);
      give_verdict();
    end
  endtask
  // Poll status until the poller reports idle, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, fws_pkg::REG_STAT, 32'h0);
      n++;
    end while (rd[fws_pkg::STAT_BUSY] !== 1'b0 && n < 300);
    if (rd[fws_pkg::STAT_BUSY] !== 1'b0) begin
      check(32'h1, 32'h0);
      give_verdict();
    end
  endtask
  task automatic run_op(input logic [1:0] m, input logic [7:0] l, input logic [15:0] w,
                        input logic [31:0] ctrl);
    fm_mode <= m;
    fm_reads <= l;
    fm_word <= w;
    fm_load <= 1'b1;
    @(posedge CLK);
    fm_load <= 1'b0;
    n_reads = 0;
    xfer(1'b1, fws_pkg::REG_ADDR, 32'h0001_2345);
    xfer(1'b1, fws_pkg::REG_CTRL, ctrl);
  endtask
  // Status under mask, number of flash reads, data word of the last read
  task automatic end_op(input int nr, input logic [7:0] mask, input logic [7:0] st,
                        input logic [15:0] d);
    wait_idle();
    check({24'h0, rd[7:0] & mask}, {24'h0, st});
    check(32'(n_reads), 32'(nr));
    xfer(1'b0, fws_pkg::REG_DATA, 32'h0);
    check({16'h0, rd[15:0]}, {16'h0, d});
    check({30'h0, FL_CE_N, FL_WE_N}, 32'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset();
    check({28'h0, FL_CE_N, FL_OE_N, FL_WE_N, AV_WAITREQUEST}, 32'hF);
    RST_B <= 1'b1;
    // Ready pin needs two synchroniser edges before status shows it
    repeat (2) @(posedge CLK);
    xfer(1'b0, fws_pkg::REG_STAT, 32'h0);
    check(rd & 32'h27, 32'h20);
  endtask
  task automatic sc_program();
    run_op(2'h0, 8'h03, 16'h5A40, 32'h1);
    xfer(1'b0, fws_pkg::REG_STAT, 32'h0);
    check(rd & 32'h21, 32'h01);
    check({11'h0, FL_ADDR}, 32'h12345);
    end_op(5, 8'hA7, 8'h22, 16'h5A40);
    run_op(2'h0, 8'h02, 16'h5A40, 32'h3);
    end_op(4, 8'hA7, 8'h22, 16'h5A40);
    run_op(2'h0, 8'h01, 16'h5A40, 32'h3);
    end_op(4, 8'hA7, 8'h22, 16'h5A40);
  endtask
  task automatic sc_erase();
    run_op(2'h1, 8'h02, 16'h12C3, 32'h5);
    end_op(4, 8'hA7, 8'h22, 16'h12C3);
    run_op(2'h1, 8'h04, 16'h12C3, 32'h3);
    end_op(6, 8'hA7, 8'h22, 16'h12C3);
    run_op(2'h2, 8'h14, 16'h12C3, 32'h3);
    end_op(3, 8'hFF, 8'h3A, 16'h1283);
  endtask
  task automatic sc_timeout();
    run_op(2'h3, 8'hFF, 16'h5A40, 32'h3);
    end_op(3, 8'hA7, 8'h86, 16'h5AA0);
    run_op(2'h3, 8'hFF, 16'h5A40, 32'h1);
    end_op(2, 8'hA7, 8'h86, 16'h5AE0);
  endtask
  // Address and start are refused mid-run; abort is the only way out
  task automatic sc_abort();
    run_op(2'h0, 8'hFF, 16'h5A40, 32'h1);
    xfer(1'b1, fws_pkg::REG_ADDR, 32'h0000_0777);
    xfer(1'b1, fws_pkg::REG_CTRL, 32'h3);
    check({11'h0, FL_ADDR}, 32'h12345);
    xfer(1'b0, fws_pkg::REG_ADDR, 32'h0);
    check(rd, 32'h12345);
    // Refused start must leave the poll mode untouched
    xfer(1'b0, fws_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, fws_pkg::REG_CTRL, 32'h8);
    wait_idle();
    check({31'h0, FL_CE_N}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RST_B = 1'b0;
    AV_ADDRESS = 4'h0;
    AV_READ = 1'b0;
    AV_WRITE = 1'b0;
    AV_WRITEDATA = 32'h0;
    AV_BYTEENABLE = 4'hF;
    fm_mode = 2'h0;
    fm_reads = 8'h00;
    fm_word = 16'h0000;
    fm_load = 1'b0;
    err_count = 0;
    n_checks = 0;
    n_reads = 0;
    // Load the flash model idle during reset so its pins are defined
    repeat (4) @(posedge CLK);
    fm_load <= 1'b1;
    repeat (4) @(posedge CLK);
    fm_load <= 1'b0;
    sc_reset();
    sc_program();
    sc_erase();
    sc_timeout();
    sc_abort();
    give_verdict();
  end
endmodule
